// *** logic/smcfg_core.sv ***
// command interpreter for the buffer, charger pass-through and registers
// Behaviour
// R01 - line status bit 1 set when minus line above full-speed threshold
// R02 - line status bit 0 from plus line; bits 7 to 2 reserved
// R03 - master puts port mask in first payload byte, bit 0 upstream
// R04 - charger byte read: address from payload 1, result to payload 2
// R05 - charger byte write: payload 2 written at payload 1 address
// R06 - charger block read: count from payload 2, results fill onward
// R07 - charger block write: following bytes written to consecutive addresses
// R08 - attach loads every runtime register with its initial value
// R09 - status registers have no initial value, follow live conditions
// R10 - access command decodes buffer from offset zero as descriptor
// R11 - buffer byte zero: 0 requests write, 1 requests read
// R12 - buffer byte one holds the number of bytes transferred
// R13 - bytes two and three hold register address, high byte first
// R14 - register data sits from byte four, written or filled by length
// R15 - master loads buffer with address, count, then descriptor and data
// R16 - master loads buffer first, then issues the access command
// R17 - access command is bytes 99h 37h then a 00h completion byte
// R18 - master reads results from offset four, may stop early
// R19 - result bytes not visible until the current command has finished
// R20 - reserved bits ignored on write and read as zero
module smcfg_core #(
  parameter int P_NUM_PORTS = 5
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  input wire logic i_buf_we,
  input wire logic i_buf_re,
  input wire logic [6:0] i_buf_addr,
  input wire logic [7:0] i_buf_wdata,
  output logic [7:0] o_buf_rdata,
  input wire logic i_cmd_valid,
  input wire logic [15:0] i_cmd_code,
  output logic o_cmd_busy,
  output logic o_cmd_done,
  input wire logic i_attach,
  input wire logic [P_NUM_PORTS-1:0] i_line_plus,
  input wire logic [P_NUM_PORTS-1:0] i_line_minus,
  input wire logic [smcfg_pkg::NSTAT-1:0][7:0] i_status_vals,
  output smcfg_pkg::smcfg_chg_s o_chg,
  input wire logic i_chg_ack,
  input wire logic [7:0] i_chg_rdata,
  output logic [smcfg_pkg::NREG-1:0][7:0] o_cfg_regs
);

  // ****************************************************************
  // state
  // ****************************************************************
  smcfg_pkg::smcfg_state_e st_q, st_d;
  logic [15:0] code_q, code_d;
  logic [15:0] base_q, base_d;
  logic [7:0] len_q, len_d;
  logic [7:0] idx_q, idx_d;
  logic dir_rd_q, dir_rd_d;
  logic [7:0] rdata_q, rdata_d;
  smcfg_pkg::smcfg_chg_s chg_q, chg_d;
  logic [7:0] mem_q [smcfg_pkg::BUF_DEPTH];
  logic [7:0] cfg_q [smcfg_pkg::NREG];
  logic [7:0] cfg_d [smcfg_pkg::NREG];

  logic mem_we;
  logic [6:0] mem_waddr;
  logic [7:0] mem_wdata;
  logic [15:0] reg_addr;
  logic reg_hit;
  logic reg_is_stat;
  logic [5:0] reg_k;
  logic [7:0] reg_val;
  logic [7:0] mask;
  logic [6:0] data_addr;
  logic chg_is_rd;
  logic chg_is_blk;
  logic last_item;
  logic cfg_we;

  assign mask = mem_q[smcfg_pkg::OFF_PAY1];
  assign data_addr = smcfg_pkg::OFF_DATA + idx_q[6:0];
  assign chg_is_rd = (code_q == smcfg_pkg::CMD_CHG_BYTE_RD) ||
                     (code_q == smcfg_pkg::CMD_CHG_BLK_RD);
  assign chg_is_blk = (code_q == smcfg_pkg::CMD_CHG_BLK_RD) ||
                      (code_q == smcfg_pkg::CMD_CHG_BLK_WR);
  // a count past the buffer end is cut short, not wrapped onto the header
  assign last_item = (idx_q + 8'h01 == len_q) ||
                     (idx_q == smcfg_pkg::DATA_LAST);
  assign reg_addr = base_q + {8'h00, idx_q};

  // ****************************************************************
  // runtime register lookup
  // ****************************************************************
  always_comb begin
    reg_hit = 1'b0;
    reg_is_stat = 1'b0;
    reg_k = 6'h00;
    reg_val = 8'h00;
    for (int k = 0; k < smcfg_pkg::NREG; k++) begin
      if (reg_addr == smcfg_pkg::CFG_ADDR[k]) begin
        reg_hit = 1'b1;
        reg_k = 6'(k);
        if (smcfg_pkg::CFG_SLOT[k] >= 0) begin
          // status registers read the live inputs [R09]
          reg_is_stat = 1'b1;
          reg_val = i_status_vals[smcfg_pkg::CFG_SLOT[k]];
        end else begin
          reg_val = cfg_q[k];
        end
      end
    end
  end

  // ****************************************************************
  // command engine, next values
  // ****************************************************************
  always_comb begin
    st_d = st_q;
    code_d = code_q;
    base_d = base_q;
    len_d = len_q;
    idx_d = idx_q;
    dir_rd_d = dir_rd_q;
    chg_d = chg_q;
    rdata_d = rdata_q;
    mem_we = 1'b0;
    mem_waddr = i_buf_addr;
    mem_wdata = i_buf_wdata;
    cfg_we = 1'b0;
    // host owns the buffer only while idle; half-written results
    // never leak out [R19]
    if (st_q == smcfg_pkg::ST_IDLE) begin
      if (i_buf_we) begin
        mem_we = 1'b1;
      end
      if (i_buf_re) begin
        rdata_d = mem_q[i_buf_addr]; // [R18]
      end
    end else begin
      rdata_d = 8'h00; // [R19]
    end
    case (st_q)
      smcfg_pkg::ST_IDLE: begin
        if (i_cmd_valid) begin
          code_d = i_cmd_code;
          idx_d = 8'h00;
          if (i_cmd_code == smcfg_pkg::CMD_LINE) begin
            st_d = smcfg_pkg::ST_LINE;
          end else if (i_cmd_code == smcfg_pkg::CMD_CHG_BYTE_RD ||
                       i_cmd_code == smcfg_pkg::CMD_CHG_BYTE_WR) begin
            base_d = {8'h00, mem_q[smcfg_pkg::OFF_PAY1]}; // [R04] [R05]
            len_d = smcfg_pkg::BYTE_LEN;
            st_d = smcfg_pkg::ST_CHG_REQ;
          end else if (i_cmd_code == smcfg_pkg::CMD_CHG_BLK_RD ||
                       i_cmd_code == smcfg_pkg::CMD_CHG_BLK_WR) begin
            base_d = {8'h00, mem_q[smcfg_pkg::OFF_PAY1]}; // [R06] [R07]
            len_d = mem_q[smcfg_pkg::OFF_PAY2];
            if (mem_q[smcfg_pkg::OFF_PAY2] == 8'h00) begin
              st_d = smcfg_pkg::ST_DONE;
            end else begin
              st_d = smcfg_pkg::ST_CHG_REQ;
            end
          end else if (i_cmd_code == smcfg_pkg::CMD_CFG_ACCESS) begin
            // descriptor decoded from offset zero [R10]
            dir_rd_d = (mem_q[smcfg_pkg::OFF_DIR] ==
                        smcfg_pkg::DIR_READ); // [R11]
            len_d = mem_q[smcfg_pkg::OFF_LEN]; // [R12]
            base_d = {mem_q[smcfg_pkg::OFF_AHI],
                      mem_q[smcfg_pkg::OFF_ALO]}; // [R13]
            // an undefined direction code writes no register and goes straight to done
            if (mem_q[smcfg_pkg::OFF_LEN] == 8'h00 ||
                (mem_q[smcfg_pkg::OFF_DIR] != smcfg_pkg::DIR_READ &&
                 mem_q[smcfg_pkg::OFF_DIR] != smcfg_pkg::DIR_WRITE)) begin
              st_d = smcfg_pkg::ST_DONE;
            end else begin
              st_d = smcfg_pkg::ST_CFG;
            end
          end else begin
            st_d = smcfg_pkg::ST_DONE;
          end
        end
      end
      smcfg_pkg::ST_LINE: begin
        // one status byte per port, unselected ports read zero
        mem_we = 1'b1;
        mem_waddr = smcfg_pkg::OFF_LINE + idx_q[6:0];
        mem_wdata = 8'h00; // [R20]
        if (mask[idx_q[2:0]]) begin
          mem_wdata[1] = i_line_minus[idx_q[2:0]]; // [R01]
          mem_wdata[0] = i_line_plus[idx_q[2:0]]; // [R02]
        end
        idx_d = idx_q + 8'h01;
        if (idx_q == 8'(P_NUM_PORTS - 1)) begin
          st_d = smcfg_pkg::ST_DONE;
        end
      end
      smcfg_pkg::ST_CHG_REQ: begin
        chg_d.req = 1'b1;
        chg_d.we = !chg_is_rd;
        chg_d.addr = base_q[7:0] + idx_q; // [R06] [R07]
        if (chg_is_blk) begin
          chg_d.wdata = mem_q[data_addr]; // [R07]
        end else begin
          chg_d.wdata = mem_q[smcfg_pkg::OFF_PAY2]; // [R05]
        end
        st_d = smcfg_pkg::ST_CHG_WAIT;
      end
      smcfg_pkg::ST_CHG_WAIT: begin
        if (i_chg_ack) begin
          chg_d.req = 1'b0;
          if (chg_is_rd) begin
            mem_we = 1'b1;
            mem_wdata = i_chg_rdata;
            if (chg_is_blk) begin
              mem_waddr = data_addr; // [R06]
            end else begin
              mem_waddr = smcfg_pkg::OFF_PAY2; // [R04]
            end
          end
          idx_d = idx_q + 8'h01;
          if (last_item) begin
            st_d = smcfg_pkg::ST_DONE;
          end else begin
            st_d = smcfg_pkg::ST_CHG_REQ;
          end
        end
      end
      smcfg_pkg::ST_CFG: begin
        // one register byte per cycle [R14]
        if (dir_rd_q) begin
          mem_we = 1'b1;
          mem_waddr = data_addr;
          mem_wdata = reg_val;
        end else if (reg_hit && !reg_is_stat) begin
          cfg_we = 1'b1;
        end
        idx_d = idx_q + 8'h01;
        if (last_item) begin
          st_d = smcfg_pkg::ST_DONE;
        end
      end
      smcfg_pkg::ST_DONE: begin
        st_d = smcfg_pkg::ST_IDLE;
      end
      default: begin
        st_d = smcfg_pkg::ST_IDLE;
      end
    endcase
  end

  // ****************************************************************
  // runtime registers, next values
  // ****************************************************************
  always_comb begin
    for (int k = 0; k < smcfg_pkg::NREG; k++) begin
      cfg_d[k] = cfg_q[k];
      if (i_attach) begin
        // attach wins over a register write in the same cycle
        cfg_d[k] = smcfg_pkg::CFG_INIT[k]; // [R08]
      end else if (cfg_we && reg_k == 6'(k)) begin
        cfg_d[k] = mem_q[data_addr]; // [R14]
      end
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q <= smcfg_pkg::ST_IDLE;
      code_q <= 16'h0000;
      base_q <= 16'h0000;
      len_q <= 8'h00;
      idx_q <= 8'h00;
      dir_rd_q <= 1'b0;
      chg_q <= '0;
      rdata_q <= 8'h00;
      for (int k = 0; k < smcfg_pkg::NREG; k++) begin
        cfg_q[k] <= smcfg_pkg::CFG_INIT[k];
      end
    end else if (i_clk_en) begin
      st_q <= st_d;
      code_q <= code_d;
      base_q <= base_d;
      len_q <= len_d;
      idx_q <= idx_d;
      dir_rd_q <= dir_rd_d;
      chg_q <= chg_d;
      rdata_q <= rdata_d;
      for (int k = 0; k < smcfg_pkg::NREG; k++) begin
        cfg_q[k] <= cfg_d[k];
      end
    end
  end

  // buffer is plain storage, no reset so it maps onto ram
  always_ff @(posedge i_sys_clk) begin
    if (i_clk_en && mem_we) begin
      mem_q[mem_waddr] <= mem_wdata;
    end
  end

  assign o_buf_rdata = rdata_q;
  assign o_cmd_busy = (st_q != smcfg_pkg::ST_IDLE);
  assign o_cmd_done = (st_q == smcfg_pkg::ST_DONE);
  assign o_chg = chg_q;
  always_comb begin
    for (int k = 0; k < smcfg_pkg::NREG; k++) begin
      o_cfg_regs[k] = cfg_q[k];
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  AST_LINE_BITS: assert property ( // [R01] [R02]
    (st_q == smcfg_pkg::ST_LINE) && mask[idx_q[2:0]] |->
      mem_wdata[1:0] == {i_line_minus[idx_q[2:0]],
                         i_line_plus[idx_q[2:0]]})
    else $error("line status bits wrong");
  AST_LINE_RSVD: assert property ( // [R20]
    (st_q == smcfg_pkg::ST_LINE) && i_clk_en |=>
      mem_q[$past(mem_waddr)][7:2] == 6'h00)
    else $error("reserved line status bits not zero");
  AST_CHG_BYTE_RD: assert property ( // [R04]
    (st_q == smcfg_pkg::ST_CHG_WAIT) && i_chg_ack && i_clk_en &&
    (code_q == smcfg_pkg::CMD_CHG_BYTE_RD) |=>
      mem_q[smcfg_pkg::OFF_PAY2] == $past(i_chg_rdata) && o_cmd_done)
    else $error("charger byte read result missing");
  AST_CHG_BYTE_WR: assert property ( // [R05]
    o_chg.req && (code_q == smcfg_pkg::CMD_CHG_BYTE_WR) |->
      o_chg.we && o_chg.addr == mem_q[smcfg_pkg::OFF_PAY1] &&
      o_chg.wdata == mem_q[smcfg_pkg::OFF_PAY2])
    else $error("charger byte write wrong");
  AST_CHG_BLK_ADDR: assert property ( // [R06] [R07]
    o_chg.req && chg_is_blk |->
      o_chg.addr == base_q[7:0] + idx_q && o_chg.we == !chg_is_rd)
    else $error("charger block address wrong");
  AST_CHG_HOLD: assert property ( // [R06]
    o_chg.req && !i_chg_ack |=> o_chg.req && $stable(o_chg.addr))
    else $error("charger request dropped before ack");
  AST_ATTACH: assert property ( // [R08]
    i_attach && i_clk_en |=>
      o_cfg_regs[smcfg_pkg::IDX_FAULT_PULLUP] == 8'hfe &&
      o_cfg_regs[0] == 8'h00)
    else $error("attach did not load initial values");
  AST_CFG_WR_DIR: assert property ( // [R11]
    cfg_we |-> !dir_rd_q && (st_q == smcfg_pkg::ST_CFG))
    else $error("register written on a read access");
  AST_CFG_LEN: assert property ( // [R12]
    (st_q == smcfg_pkg::ST_CFG) |-> idx_q < len_q)
    else $error("access ran past its length");
  AST_CFG_RD: assert property ( // [R14]
    (st_q == smcfg_pkg::ST_CFG) && dir_rd_q && i_clk_en |=>
      mem_q[$past(data_addr)] == $past(reg_val))
    else $error("register read not stored at data offset");
  AST_BUSY_HIDE: assert property ( // [R19]
    o_cmd_busy && i_clk_en |=> o_buf_rdata == 8'h00)
    else $error("buffer visible during a command");
  AST_LINE_TIME: assert property ( // [R19]
    $rose(st_q == smcfg_pkg::ST_LINE) ##0 i_clk_en [*5] |=> o_cmd_done)
    else $error("line status command not done in time");

  COV_LINE: cover property (
    (st_q == smcfg_pkg::ST_LINE) ##[1:8] o_cmd_done);
  COV_BLK_RD: cover property (
    o_chg.req && chg_is_blk && chg_is_rd ##[1:40] o_cmd_done);
  COV_CFG_RD: cover property (
    (st_q == smcfg_pkg::ST_CFG) && dir_rd_q && reg_hit);
  COV_CFG_WR: cover property (cfg_we ##1 o_cmd_done);

endmodule

// *** logic/smcfg_pkg.sv ***
// shared constants, buffer layout, runtime register map and types
package smcfg_pkg;

  // ****************************************************************
  // buffer layout
  // ****************************************************************
  localparam int BUF_DEPTH = 128;
  localparam logic [6:0] OFF_DIR = 7'h00;
  localparam logic [6:0] OFF_LEN = 7'h01;
  localparam logic [6:0] OFF_AHI = 7'h02;
  localparam logic [6:0] OFF_ALO = 7'h03;
  localparam logic [6:0] OFF_DATA = 7'h04;
  localparam logic [6:0] OFF_PAY1 = 7'h02;
  localparam logic [6:0] OFF_PAY2 = 7'h03;
  localparam logic [6:0] OFF_LINE = 7'h03;
  // last data index that still lands inside the buffer
  localparam logic [7:0] DATA_LAST = 8'h7b;
  localparam logic [7:0] DIR_WRITE = 8'h00;
  localparam logic [7:0] DIR_READ = 8'h01;
  localparam logic [7:0] BYTE_LEN = 8'h01;

  // ****************************************************************
  // command codes
  // ****************************************************************
  localparam logic [15:0] CMD_LINE = 16'h0083;
  localparam logic [15:0] CMD_CHG_BYTE_RD = 16'h0084;
  localparam logic [15:0] CMD_CHG_BYTE_WR = 16'h0085;
  localparam logic [15:0] CMD_CHG_BLK_RD = 16'h0086;
  localparam logic [15:0] CMD_CHG_BLK_WR = 16'h0087;
  localparam logic [15:0] CMD_CFG_ACCESS = 16'h9937;

  // ****************************************************************
  // runtime register map
  // ****************************************************************
  localparam int NREG = 45;
  localparam int NSTAT = 9;
  localparam logic [15:0] CFG_ADDR [NREG] = '{
    16'h0806, 16'h0807, 16'h0808, 16'h0809, 16'h082d, 16'h082f,
    16'h0831, 16'h0833, 16'h0835, 16'h0837, 16'h0839, 16'h083b,
    16'h083d, 16'h083f, 16'h092e, 16'h0932, 16'h0936, 16'h093a,
    16'h093e, 16'h3c00, 16'h3c04, 16'h3c08, 16'h3c0c, 16'h3c20,
    16'h3c24, 16'h3c28, 16'h3c2c, 16'h5246, 16'h525a, 16'h525b,
    16'h60ca, 16'h60cc, 16'h61c0, 16'h64ca, 16'h64cc, 16'h65c0,
    16'h68ca, 16'h68cc, 16'h69c0, 16'h6cca, 16'h6ccc, 16'h6dc0,
    16'h70ca, 16'h70cc, 16'h71c0};
  localparam logic [7:0] CFG_INIT [NREG] = '{
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'hfe, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h03, 8'h03, 8'h03, 8'h03, 8'h01, 8'h01, 8'h01, 8'h01,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  // status input slot per register, -1 for stored registers
  localparam int CFG_SLOT [NREG] = '{
    -1, -1, -1, -1, -1, -1, -1, -1, -1, -1, 0, 1, -1, -1, -1,
    -1, -1, 2, -1, -1, -1, -1, -1, -1, -1, -1, -1, 3, -1, -1,
    -1, -1, 4, -1, -1, 5, -1, -1, 6, -1, -1, 7, -1, -1, 8};
  localparam int IDX_FAULT_PULLUP = 12;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_LINE = 6'b000010,
    ST_CHG_REQ = 6'b000100,
    ST_CHG_WAIT = 6'b001000,
    ST_CFG = 6'b010000,
    ST_DONE = 6'b100000
  } smcfg_state_e;

  typedef struct packed {
    logic req;
    logic we;
    logic [7:0] addr;
    logic [7:0] wdata;
  } smcfg_chg_s;

endpackage

// *** verification/smcfg_chg_model.sv ***
// charger port controller stand-in for the pass-through commands
module smcfg_chg_model (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire smcfg_pkg::smcfg_chg_s i_chg,
  input wire logic [3:0] i_delay,
  output logic o_ack,
  output logic [7:0] o_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [256];
  logic [3:0] wait_q;

  // ****************************************************************
  // request answer
  // ****************************************************************
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_ack <= 1'b0;
      wait_q <= 4'h0;
      o_rdata <= 8'h00;
    end else begin
      o_ack <= 1'b0;
      // read data is only good in the ack cycle, so it churns elsewhere
      o_rdata <= ~o_rdata;
      if (i_chg.req && !o_ack) begin
        if (wait_q == i_delay) begin
          o_ack <= 1'b1;
          wait_q <= 4'h0;
          if (i_chg.we) begin
            mem[i_chg.addr] <= i_chg.wdata;
          end else begin
            o_rdata <= mem[i_chg.addr];
          end
        end else begin
          wait_q <= wait_q + 4'h1;
        end
      end
    end
  end
endmodule

// *** verification/tb.sv ***
// self-checking bench for the command interpreter
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [7:0] mask;
    logic [4:0] plus;
    logic [4:0] minus;
    logic [39:0] exp;
  } smcfg_row_s;
  logic i_sys_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_clk_en = 1'b1;
  logic i_buf_we = 1'b0;
  logic i_buf_re = 1'b0;
  logic [6:0] i_buf_addr = 7'h00;
  logic [7:0] i_buf_wdata = 8'h00;
  logic [7:0] o_buf_rdata;
  logic i_cmd_valid = 1'b0;
  logic [15:0] i_cmd_code = 16'h0000;
  logic o_cmd_busy;
  logic o_cmd_done;
  logic i_attach = 1'b0;
  logic [4:0] i_line_plus = 5'h00;
  logic [4:0] i_line_minus = 5'h00;
  logic [smcfg_pkg::NSTAT-1:0][7:0] i_status_vals = '0;
  smcfg_pkg::smcfg_chg_s o_chg;
  logic i_chg_ack;
  logic [7:0] i_chg_rdata;
  logic [smcfg_pkg::NREG-1:0][7:0] o_cfg_regs;
  logic [3:0] delay = 4'h0;
  logic [7:0] d;
  int fail_count = 0;
  int num_checks = 0;
  int cycles = 0;
  smcfg_row_s rows [3] = '{
    '{8'h1f, 5'b00101, 5'b11010, 40'h0102010202},
    '{8'h0a, 5'b11111, 5'b11111, 40'h0003000300},
    '{8'h01, 5'b00001, 5'b00001, 40'h0300000000}};

  smcfg_core u_smcfg_core (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_clk_en(i_clk_en),
    .i_buf_we(i_buf_we), .i_buf_re(i_buf_re), .i_buf_addr(i_buf_addr),
    .i_buf_wdata(i_buf_wdata), .o_buf_rdata(o_buf_rdata),
    .i_cmd_valid(i_cmd_valid), .i_cmd_code(i_cmd_code),
    .o_cmd_busy(o_cmd_busy), .o_cmd_done(o_cmd_done),
    .i_attach(i_attach), .i_line_plus(i_line_plus),
    .i_line_minus(i_line_minus), .i_status_vals(i_status_vals),
    .o_chg(o_chg), .i_chg_ack(i_chg_ack), .i_chg_rdata(i_chg_rdata),
    .o_cfg_regs(o_cfg_regs));

  smcfg_chg_model u_smcfg_chg_model (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_chg(o_chg),
    .i_delay(delay), .o_ack(i_chg_ack), .o_rdata(i_chg_rdata));

  always #25 i_sys_clk = ~i_sys_clk;

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  // strobe stays high between writes; the next access lowers it
  task automatic bwr(input logic [6:0] a, input logic [7:0] v);
    @(posedge i_sys_clk);
    i_buf_we <= 1'b1;
    i_buf_addr <= a;
    i_buf_wdata <= v;
  endtask

  task automatic brd(input logic [6:0] a, output logic [7:0] v);
    @(posedge i_sys_clk);
    i_buf_we <= 1'b0;
    i_buf_re <= 1'b1;
    i_buf_addr <= a;
    @(posedge i_sys_clk);
    i_buf_re <= 1'b0;
    @(negedge i_sys_clk);
    v = o_buf_rdata;
  endtask

  task automatic run_cmd(input logic [15:0] code);
    int n;
    n = 0;
    @(posedge i_sys_clk);
    i_buf_we <= 1'b0;
    i_cmd_valid <= 1'b1;
    i_cmd_code <= code;
    @(posedge i_sys_clk);
    i_cmd_valid <= 1'b0;
    do begin
      @(negedge i_sys_clk);
      n++;
    end while (o_cmd_done !== 1'b1 && n < 400);
    chk("done seen", 8'h01, {7'h00, o_cmd_done});
    @(negedge i_sys_clk);
    chk("busy after done", 8'h00, {7'h00, o_cmd_busy});
  endtask

  task automatic cfg(input logic [7:0] dir, input logic [7:0] len,
                     input logic [15:0] a);
    bwr(smcfg_pkg::OFF_DIR, dir);
    bwr(smcfg_pkg::OFF_LEN, len);
    bwr(smcfg_pkg::OFF_AHI, a[15:8]);
    bwr(smcfg_pkg::OFF_ALO, a[7:0]);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  always @(posedge i_sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    repeat (3) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    @(negedge i_sys_clk);
    for (int i = 0; i < smcfg_pkg::NREG; i++) begin
      d = (smcfg_pkg::CFG_SLOT[i] < 0) ? smcfg_pkg::CFG_INIT[i] : 8'h00;
      chk("reset register", d, o_cfg_regs[i]);
    end
    chk("reset request", 8'h00, {7'h00, o_chg.req});
    foreach (rows[r]) begin
      @(posedge i_sys_clk);
      i_line_plus <= rows[r].plus;
      i_line_minus <= rows[r].minus;
      bwr(smcfg_pkg::OFF_PAY1, rows[r].mask);
      run_cmd(smcfg_pkg::CMD_LINE);
      for (int p = 0; p < 5; p++) begin
        brd(smcfg_pkg::OFF_LINE + 7'(p), d);
        chk("line status", rows[r].exp[39-8*p -: 8], d);
      end
    end
    // register write then read back with one byte beyond
    cfg(smcfg_pkg::DIR_WRITE, 8'h02, 16'h0806);
    bwr(7'h04, 8'h5a);
    bwr(7'h05, 8'ha5);
    run_cmd(smcfg_pkg::CMD_CFG_ACCESS);
    chk("written reg0", 8'h5a, o_cfg_regs[0]);
    chk("written reg1", 8'ha5, o_cfg_regs[1]);
    chk("untouched reg2", 8'h00, o_cfg_regs[2]);
    cfg(smcfg_pkg::DIR_READ, 8'h03, 16'h0806);
    run_cmd(smcfg_pkg::CMD_CFG_ACCESS);
    brd(7'h04, d);
    chk("read reg0", 8'h5a, d);
    brd(7'h05, d);
    chk("read reg1", 8'ha5, d);
    brd(7'h06, d);
    chk("read reg2", 8'h00, d);
    // live status register
    @(posedge i_sys_clk);
    i_status_vals[0] <= 8'h3c;
    cfg(smcfg_pkg::DIR_READ, 8'h01, 16'h0839);
    run_cmd(smcfg_pkg::CMD_CFG_ACCESS);
    brd(7'h04, d);
    chk("status read", 8'h3c, d);
    // unknown direction byte must leave registers alone
    cfg(8'h02, 8'h01, 16'h0806);
    bwr(7'h04, 8'hee);
    run_cmd(smcfg_pkg::CMD_CFG_ACCESS);
    chk("bad direction", 8'h5a, o_cfg_regs[0]);
    // attach restores initial values
    cfg(smcfg_pkg::DIR_WRITE, 8'h01, 16'h083d);
    bwr(7'h04, 8'hd3);
    run_cmd(smcfg_pkg::CMD_CFG_ACCESS);
    d = o_cfg_regs[smcfg_pkg::IDX_FAULT_PULLUP];
    chk("pullup written", 8'hd3, d);
    // attach must wait while the clock enable is low
    @(posedge i_sys_clk);
    i_clk_en <= 1'b0;
    i_attach <= 1'b1;
    @(posedge i_sys_clk);
    @(negedge i_sys_clk);
    d = o_cfg_regs[smcfg_pkg::IDX_FAULT_PULLUP];
    chk("frozen pullup", 8'hd3, d);
    @(posedge i_sys_clk);
    i_clk_en <= 1'b1;
    @(posedge i_sys_clk);
    i_attach <= 1'b0;
    @(negedge i_sys_clk);
    d = o_cfg_regs[smcfg_pkg::IDX_FAULT_PULLUP];
    chk("attach pullup", 8'hfe, d);
    chk("attach reg0", 8'h00, o_cfg_regs[0]);
    // charger byte write, then slow byte read
    bwr(smcfg_pkg::OFF_PAY1, 8'h10);
    bwr(smcfg_pkg::OFF_PAY2, 8'h77);
    run_cmd(smcfg_pkg::CMD_CHG_BYTE_WR);
    chk("charger write", 8'h77, u_smcfg_chg_model.mem[8'h10]);
    delay <= 4'h5;
    bwr(smcfg_pkg::OFF_PAY2, 8'h00);
    run_cmd(smcfg_pkg::CMD_CHG_BYTE_RD);
    brd(smcfg_pkg::OFF_PAY2, d);
    chk("charger read", 8'h77, d);
    // block across the address wrap
    delay <= 4'h0;
    bwr(smcfg_pkg::OFF_PAY1, 8'hfe);
    bwr(smcfg_pkg::OFF_PAY2, 8'h03);
    for (int i = 0; i < 3; i++) bwr(7'h04 + 7'(i), 8'(8'h11 * (i + 1)));
    run_cmd(smcfg_pkg::CMD_CHG_BLK_WR);
    chk("block write end", 8'h33, u_smcfg_chg_model.mem[8'h00]);
    for (int i = 0; i < 3; i++) bwr(7'h04 + 7'(i), 8'h00);
    delay <= 4'h3;
    run_cmd(smcfg_pkg::CMD_CHG_BLK_RD);
    for (int i = 0; i < 3; i++) begin
      brd(7'h04 + 7'(i), d);
      chk("block read", 8'(8'h11 * (i + 1)), d);
    end
    tally_and_finish();
  end
endmodule
